/* File: shared/plbb_defines.vh */
`ifndef PLBB_DEFINES_VH
`define PLBB_DEFINES_VH
// Pin configuration codes
`define PLBB_CFG_HOST_MODE_A 3'h0
`define PLBB_CFG_GP_HI 3'h2
`define PLBB_CFG_GP_SSC 3'h3
`define PLBB_CFG_GP_GP 3'h4
// Reset values of local bus configuration
`define PLBB_RST_WAIT 4'hf
`define PLBB_RST_WIDE 1'b1
`define PLBB_RST_MUX 1'b0
// Wait counts: strobe floor is two clocks, latch strobe one clock
`define PLBB_WAIT_MAX 4'hf
`define PLBB_STROBE_MIN 4'h2
`define PLBB_LATCH_CYC 4'h1
// PCI data phase limit in clocks, kept for reference
`define PLBB_PCI_LIMIT 16
`endif

/* File: hdl/plbb_wait_timer.v */
`include "plbb_defines.vh"
module plbb_wait_timer (
   input wire mclk,
   input wire rst_b,
   input wire start,
   input wire [3:0] cycle_wait_count,
   input wire ready_wait_enable,
   input wire ready_sync_n,
   output wire done
);
   reg [4:0] count;
   reg running;
   wire [4:0] target;
   wire [3:0] pre;

   // With ready control only the low three bits act as prewait
   assign pre = ready_wait_enable ? {1'b0, cycle_wait_count[2:0]} :
      (`PLBB_WAIT_MAX - cycle_wait_count);
   assign target = {1'b0, pre} + {1'b0, `PLBB_STROBE_MIN} - 5'h01;
   // Ready sampled only after the prewait has run out
   assign done = running && (count >= target) &&
      (!ready_wait_enable || !ready_sync_n);

   // Strobe length counter
   always @(posedge mclk) begin
      if (!rst_b) begin
         count <= 5'h00;
         running <= 1'b0;
      end else if (start) begin
         count <= 5'h00;
         running <= 1'b1;
      end else if (done) begin
         running <= 1'b0;
      end else if (running && count != 5'h1f) begin
         count <= count + 5'h01;
      end
   end
endmodule

/* File: hdl/plbb_bridge.v */
// Functional notes
// - Three-bit pin config routes upper address, lower address, data groups.
// - Port exists only in PCI mode; host_mode_a makes pins address 15..0.
// - Slave reads to local bus retry until local data is ready.
// - Retried reads complete without added target wait states.
// - Slave write captures one word, completes at once, then posted.
// - Further write during a pending posted write is retried.
// - Only single data phase slave transfers; bursts are disconnected.
// - Write cycle length follows wait count and ready input.
// - Bus master with 8 or 16 bit, muxed or demuxed cycles.
// - Controller may be arbitration master or arbitration slave.
// - Sixteen bit muxed mode shares address and data pins.
// - Eight bit muxed holds upper address on upper data pins.
// - Sixteen bit muxed word access ignores address bit zero.
// - Demuxed mode drives address continuously on address pins.
// - Muxed cycle: latch strobe, address, falling edge, then command.
// - Read captures data then drops command; peripheral releases bus.
// - Write data stays driven until the next bus cycle starts.
// - Fifteen minus wait count wait states; strobe at least two clocks.
// - Ready mode: 0 to 7 prewait states then sample ready low.
// - Reset to 16 bit demuxed (here bus_wide and bus_mux are inputs, not reset); idle after a read floats data, holds address.
`include "plbb_defines.vh"
module plbb_bridge (
   input wire mclk,
   input wire rst_b,
   // Straps and configuration
   input wire host_mode_a,
   input wire [2:0] peripheral_pin_config,
   input wire [3:0] cycle_wait_count,
   input wire ready_wait_enable,
   input wire bus_wide,
   input wire bus_mux,
   input wire arb_master,
   input wire bus_granted,
   input wire [31:0] host_addr_in,
   // PCI target request side
   input wire pci_req,
   input wire pci_write,
   input wire pci_burst,
   input wire [31:0] pci_addr,
   input wire [31:0] pci_wdata,
   output wire pci_ack,
   output wire pci_retry,
   output wire pci_disconnect,
   output reg [31:0] pci_rdata,
   // Local bus pins
   output reg local_addr_latch_strobe,
   output reg local_read_strobe,
   output reg local_write_strobe,
   input wire local_ready_n,
   output reg [15:0] local_address_pins,
   input wire [15:0] local_data_pins_in,
   output reg [15:0] local_data_pins_out,
   output reg local_data_pins_oe,
   // Shared pin routing outputs
   output reg [15:0] shared_addr_out,
   output reg [7:0] general_purpose_pins_en,
   output reg sync_serial_block_en,
   output reg local_mux_addr_data_en,
   output reg pins_host_addr,
   output reg local_busy
);
   localparam ST_IDLE = 6'h01;
   localparam ST_ARB = 6'h02;
   localparam ST_ALE = 6'h04;
   localparam ST_ADDR = 6'h08;
   localparam ST_CMD = 6'h10;
   localparam ST_END = 6'h20;

   reg [5:0] state;
   reg [5:0] next_state;
   reg pend_valid;
   reg pend_write;
   reg rd_ready;
   reg [31:0] pend_addr;
   reg [31:0] pend_data;
   reg [15:0] rd_data;
   reg ready_meta;
   reg ready_sync_n;
   reg [15:0] last_addr;
   wire timer_start;
   wire timer_done;
   wire [15:0] cyc_addr;
   wire lbi_on;

   // True when the config code enables a local bus at all
   function cfg_has_bus;
      input [2:0] code;
      begin
         cfg_has_bus = (code == `PLBB_CFG_HOST_MODE_A) ||
            (code == `PLBB_CFG_GP_HI) || (code == `PLBB_CFG_GP_SSC) ||
            (code == `PLBB_CFG_GP_GP);
      end
   endfunction

   // True when the config code forces multiplexed address/data
   function cfg_forces_mux;
      input [2:0] code;
      begin
         cfg_forces_mux = (code == `PLBB_CFG_GP_SSC) ||
            (code == `PLBB_CFG_GP_GP);
      end
   endfunction

   // Local bus only exists in PCI mode reserved codes idle it
   assign lbi_on = !host_mode_a && cfg_has_bus(peripheral_pin_config);

   // Word address: bit 0 dropped in 16 bit mode
   assign cyc_addr = bus_wide ? {pend_addr[15:1], 1'b0} : pend_addr[15:0];

   // Pin group routing
   always @(posedge mclk) begin
      if (!rst_b) begin
         general_purpose_pins_en <= 8'h00;
         sync_serial_block_en <= 1'b0;
         local_mux_addr_data_en <= 1'b0;
         pins_host_addr <= 1'b0;
      end else begin
         pins_host_addr <= host_mode_a;
         sync_serial_block_en <= !host_mode_a &&
            peripheral_pin_config == `PLBB_CFG_GP_SSC;
         local_mux_addr_data_en <= !host_mode_a &&
            cfg_forces_mux(peripheral_pin_config);
         general_purpose_pins_en <= 8'h00;
         if (!host_mode_a && peripheral_pin_config != `PLBB_CFG_HOST_MODE_A &&
               lbi_on)
            general_purpose_pins_en <= 8'hff;
      end
   end

   // Shared upper and lower address groups carry host address in A mode
   always @(posedge mclk) begin
      if (!rst_b)
         shared_addr_out <= 16'h0000;
      else if (host_mode_a)
         shared_addr_out <= host_addr_in[15:0];
      else
         shared_addr_out <= local_address_pins;
   end

   // Ready pin synchroniser, second stage feeds the timer
   always @(posedge mclk) begin
      if (!rst_b) begin
         ready_meta <= 1'b1;
         ready_sync_n <= 1'b1;
      end else begin
         ready_meta <= local_ready_n;
         ready_sync_n <= ready_meta;
      end
   end

   // PCI answers are combinational: first match wins
   wire same_read = pend_valid && !pend_write && pend_addr == pci_addr;
   wire take_write = pci_req && pci_write && !pend_valid && lbi_on;
   wire take_read = pci_req && !pci_write && !pend_valid && lbi_on;
   // Gated like new requests so a stale read never completes in A mode
   wire read_hit = pci_req && !pci_write && same_read && rd_ready && lbi_on;
   assign pci_ack = take_write || read_hit;
   assign pci_retry = pci_req && !pci_ack;
   assign pci_disconnect = pci_ack && pci_burst; // Single phase

   // Posted write / retried read bookkeeping
   always @(posedge mclk) begin
      if (!rst_b) begin
         pend_valid <= 1'b0;
         pend_write <= 1'b0;
         rd_ready <= 1'b0;
         pend_addr <= 32'h00000000;
         pend_data <= 32'h00000000;
         pci_rdata <= 32'h00000000;
      end else if (take_write) begin
         pend_valid <= 1'b1; // Posted
         pend_write <= 1'b1;
         pend_addr <= pci_addr;
         pend_data <= pci_wdata;
      end else if (take_read) begin
         pend_valid <= 1'b1; // Retry now, fetch locally
         pend_write <= 1'b0;
         rd_ready <= 1'b0;
         pend_addr <= pci_addr;
      end else if (read_hit) begin
         pend_valid <= 1'b0; // Data handed over on the retry
         rd_ready <= 1'b0;
      end else if (state == ST_END) begin
         if (pend_write)
            pend_valid <= 1'b0;
         else begin
            rd_ready <= 1'b1;
            pci_rdata <= {16'h0000, rd_data};
         end
      end
   end

   assign timer_start = next_state == ST_CMD && state != ST_CMD;

   plbb_wait_timer u_timer (
      .mclk(mclk),
      .rst_b(rst_b),
      .start(timer_start),
      .cycle_wait_count(cycle_wait_count),
      .ready_wait_enable(ready_wait_enable),
      .ready_sync_n(ready_sync_n),
      .done(timer_done)
   );

   wire is_mux = bus_mux || cfg_forces_mux(peripheral_pin_config);

   // Cycle sequencer
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (pend_valid && (pend_write || !rd_ready) && lbi_on)
               next_state = ST_ARB;
         end
         ST_ARB: begin
            // Slave waits for grant, master owns by default
            if (arb_master || bus_granted)
               next_state = is_mux ? ST_ALE : ST_CMD;
         end
         ST_ALE: next_state = ST_ADDR;
         ST_ADDR: next_state = ST_CMD;
         ST_CMD: begin
            if (timer_done)
               next_state = ST_END;
         end
         ST_END: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   always @(posedge mclk) begin
      if (!rst_b)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   // Pin drivers; idle floats data after reads, holds address, strobes high
   always @(posedge mclk) begin
      if (!rst_b) begin
         local_addr_latch_strobe <= 1'b0;
         local_read_strobe <= 1'b1;
         local_write_strobe <= 1'b1;
         local_address_pins <= 16'h0000;
         local_data_pins_out <= 16'h0000;
         local_data_pins_oe <= 1'b0;
         rd_data <= 16'h0000;
         last_addr <= 16'h0000;
         local_busy <= 1'b0;
      end else begin
         local_busy <= state != ST_IDLE;
         local_addr_latch_strobe <= next_state == ST_ALE;
         if (next_state == ST_ALE) begin
            // Address on shared pins while strobe high
            local_data_pins_oe <= 1'b1;
            local_data_pins_out <= cyc_addr;
            local_address_pins <= cyc_addr;
            last_addr <= cyc_addr;
         end else if (state == ST_ARB && next_state == ST_CMD) begin
            // Demuxed: address stays on address pins
            local_address_pins <= cyc_addr;
            last_addr <= cyc_addr;
         end
         if (timer_start) begin
            local_read_strobe <= pend_write;
            local_write_strobe <= !pend_write;
            if (pend_write) begin
               local_data_pins_oe <= 1'b1;
               if (bus_wide)
                  local_data_pins_out <= pend_data[15:0];
               else
                  local_data_pins_out <= {cyc_addr[15:8],
                     pend_data[7:0]}; // Upper address held
            end else if (is_mux && bus_wide) begin
               local_data_pins_oe <= 1'b0; // Address removed
            end else if (is_mux) begin
               local_data_pins_oe <= 1'b1; // Single enable: low byte driven as zero, upper address held
               local_data_pins_out <= {cyc_addr[15:8], 8'h00};
            end else begin
               local_data_pins_oe <= 1'b0;
            end
         end
         if (state == ST_CMD && timer_done) begin
            local_read_strobe <= 1'b1;
            local_write_strobe <= 1'b1;
            // Peripheral drives data during the strobe
            if (!pend_write) begin
               rd_data <= bus_wide ? local_data_pins_in :
                  {8'h00, local_data_pins_in[7:0]};
               local_data_pins_oe <= 1'b0;
            end
            // Write data kept driven until next cycle starts
         end
         if (state == ST_END && !pend_write)
            local_address_pins <= last_addr;
      end
   end
endmodule

/* File: dv/plbb_periph_model.sv */
module plbb_periph_model (
   input wire mclk,
   input wire bus_mux,
   input wire [4:0] rdy_dly,
   input wire local_addr_latch_strobe,
   input wire local_read_strobe,
   input wire local_write_strobe,
   input wire [15:0] local_address_pins,
   input wire [15:0] local_data_pins_out,
   output logic local_ready_n = 1'b1,
   output logic [15:0] local_data_pins_in = 16'h0,
   output logic [15:0] wr_a,
   output logic [15:0] wr_d
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] lat;
   logic [4:0] n = 5'h0;
   wire idle = local_read_strobe & local_write_strobe;
   wire [15:0] a = bus_mux ? lat : local_address_pins;
   // Word access, so address bit 0 is dropped; bytes swapped to expose both
   wire [15:0] f = {a[7:1], 1'b0, a[15:8]} ^ 16'h5a5a;
   // Full 16-bit latch, caught on the falling latch strobe
   always @(negedge local_addr_latch_strobe)
      lat = local_data_pins_out;
   // Ready low only after rdy_dly clocks of command
   always @(posedge mclk) begin
      n <= idle ? 5'h0 : n + 5'h1;
      local_ready_n <= idle | (n < rdy_dly);
   end
   // Data one clock into the read; toggling junk once released
   always @(posedge mclk) begin
      if (!local_read_strobe) begin
         local_data_pins_in <= f;
      end else begin
         local_data_pins_in <= ~local_data_pins_in;
      end
   end
   // Write taken at the trailing strobe edge
   always @(posedge local_write_strobe) begin
      wr_a = a;
      wr_d = local_data_pins_out;
   end
endmodule

/* File: dv/plbb_bridge_assertions.sv */
module plbb_bridge_assertions (
   input wire mclk,
   input wire rst_b,
   input wire host_mode_a,
   input wire [2:0] peripheral_pin_config,
   input wire [3:0] cycle_wait_count,
   input wire ready_wait_enable,
   input wire bus_wide,
   input wire bus_mux,
   input wire pci_req,
   input wire pci_ack,
   input wire pci_retry,
   input wire local_addr_latch_strobe,
   input wire local_read_strobe,
   input wire local_write_strobe,
   input wire [15:0] local_address_pins,
   input wire [15:0] local_data_pins_out,
   input wire local_data_pins_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   wire cmd_idle = local_read_strobe & local_write_strobe;
   // Eight bit muxed cycles keep the upper address on the data pins
   wire mux8 = !bus_wide && (bus_mux || peripheral_pin_config == 3'h3 ||
      peripheral_pin_config == 3'h4);
   logic [4:0] low_cnt;
   // Clocks the command strobe has been low
   always @(posedge mclk) begin
      if (!rst_b || cmd_idle) low_cnt <= 5'h0;
      else low_cnt <= low_cnt + 5'h1;
   end
   a_one_answer: assert property (
      pci_req == (pci_ack ^ pci_retry)) else $error("ack with retry");
   a_host_refuse: assert property (
      pci_req && host_mode_a |-> pci_retry && !pci_ack)
      else $error("host mode not refused");
   a_reserved_refuse: assert property (
      pci_req && !host_mode_a && peripheral_pin_config inside
      {3'h1, 3'h5, 3'h6, 3'h7} |-> pci_retry) else $error("bad code taken");
   a_strobe_width: assert property (
      $rose(cmd_idle) && !ready_wait_enable |->
      low_cnt == 5'd17 - {1'b0, cycle_wait_count}) else $error("width");
   a_prewait_floor: assert property (
      $rose(cmd_idle) && ready_wait_enable |->
      low_cnt >= 5'd2 + cycle_wait_count[2:0]) else $error("prewait");
   a_latch_then_cmd: assert property (
      $fell(local_addr_latch_strobe) |=> !cmd_idle) else $error("no cmd");
   a_latch_drives: assert property (
      local_addr_latch_strobe |-> local_data_pins_oe && cmd_idle)
      else $error("latch phase");
   a_read_floats: assert property (
      !local_read_strobe && !mux8 |-> !local_data_pins_oe)
      else $error("read oe");
   a_upper_held: assert property (
      !local_read_strobe && mux8 |-> local_data_pins_oe &&
      local_data_pins_out[15:8] == local_address_pins[15:8])
      else $error("upper address not held");
   a_write_hold: assert property (
      $rose(local_write_strobe) |=> local_data_pins_oe &&
      $stable(local_data_pins_out)) else $error("write data lost");
   a_addr_steady: assert property (
      !cmd_idle ##1 !cmd_idle |-> $stable(local_address_pins))
      else $error("address moved");
endmodule
bind plbb_bridge plbb_bridge_assertions i_plbb_bridge_assertions (
   .mclk, .rst_b, .host_mode_a, .peripheral_pin_config, .cycle_wait_count,
   .ready_wait_enable, .bus_wide, .bus_mux, .pci_req, .pci_ack, .pci_retry,
   .local_addr_latch_strobe, .local_read_strobe, .local_write_strobe,
   .local_address_pins, .local_data_pins_out, .local_data_pins_oe);

/* File: dv/plbb_bridge_tb.sv */
module plbb_bridge_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 0, rst_b = 0, host_mode_a = 0, ready_wait_enable = 0;
   logic bus_wide = 1, bus_mux = 0, arb_master = 1, bus_granted = 1;
   logic pci_req = 0, pci_write = 0, pci_burst = 0;
   logic [2:0] peripheral_pin_config = 3'h0, res;
   logic [3:0] cycle_wait_count = 4'hf;
   logic [4:0] rdy_dly = 5'h0;
   logic [31:0] host_addr_in = 32'h0, pci_addr = 32'h0, pci_wdata = 32'h0;
   wire pci_ack, pci_retry, pci_disconnect, local_addr_latch_strobe;
   wire local_read_strobe, local_write_strobe, local_ready_n, local_busy;
   wire sync_serial_block_en, local_mux_addr_data_en, pins_host_addr;
   wire local_data_pins_oe;
   wire [7:0] general_purpose_pins_en;
   wire [31:0] pci_rdata;
   wire [15:0] local_address_pins, local_data_pins_in, local_data_pins_out;
   wire [15:0] shared_addr_out, wr_a, wr_d;
   int fails = 0, n_checks = 0, lows;
   plbb_bridge i_plbb_bridge (.mclk, .rst_b, .host_mode_a,
      .peripheral_pin_config, .cycle_wait_count, .ready_wait_enable,
      .bus_wide, .bus_mux, .arb_master, .bus_granted, .host_addr_in,
      .pci_req, .pci_write, .pci_burst, .pci_addr, .pci_wdata, .pci_ack,
      .pci_retry, .pci_disconnect, .pci_rdata, .local_addr_latch_strobe,
      .local_read_strobe, .local_write_strobe, .local_ready_n,
      .local_address_pins, .local_data_pins_in, .local_data_pins_out,
      .local_data_pins_oe, .shared_addr_out, .general_purpose_pins_en,
      .sync_serial_block_en, .local_mux_addr_data_en, .pins_host_addr,
      .local_busy);
   plbb_periph_model i_plbb_periph_model (.mclk, .bus_mux, .rdy_dly,
      .local_addr_latch_strobe, .local_read_strobe, .local_write_strobe,
      .local_address_pins, .local_data_pins_out, .local_ready_n,
      .local_data_pins_in, .wr_a, .wr_d);
   // 100 MHz system clock
   always #5 mclk = ~mclk;
   task automatic chk(logic [31:0] g, logic [31:0] e, string m);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("BAD %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // One request cycle; answer is combinational, so sample mid-cycle
   task automatic req(logic w, logic b, logic [31:0] a, logic [31:0] d);
      @(posedge mclk);
      pci_req <= 1'b1;
      pci_write <= w;
      pci_burst <= b;
      pci_addr <= a;
      pci_wdata <= d;
      #1;
      res = {pci_disconnect, pci_retry, pci_ack};
      @(posedge mclk);
      pci_req <= 1'b0;
   endtask
   // Bounded wait for the local cycle to finish
   task automatic idle();
      repeat (3) @(posedge mclk);
      #1;
      for (int i = 0; local_busy !== 1'b0; i++) begin
         if (i == 300) begin
            fails++;
            wrap_up();
         end
         #10;
      end
   endtask
   // Repeat a read until it is answered with data
   task automatic poll(logic [31:0] a);
      for (int i = 0; i < 100; i++) begin
         req(1'b0, 1'b0, a, 32'h0);
         if (res[0] === 1'b1) return;
      end
      fails++;
      wrap_up();
   endtask
   task automatic count_low(int n);
      lows = 0;
      #1;
      repeat (n) begin
         lows += (local_write_strobe === 1'b0);
         #10;
      end
   endtask
   task automatic t_write();
      req(1'b1, 1'b0, 32'h1235, 32'hcafe_beef);
      chk(res, 3'b001, "post");
      req(1'b1, 1'b0, 32'h2222, 32'h0);
      chk(res, 3'b010, "again");
      idle();
      chk({wr_a, wr_d}, 32'h1234_beef, "wr");
      chk({local_data_pins_oe, local_data_pins_out}, 17'h1_beef,
         "hold");
      req(1'b1, 1'b1, 32'h0040, 32'h5);
      chk(res, 3'b101, "burst");
      idle();
      $display("t_write done");
   endtask
   task automatic t_read();
      req(1'b0, 1'b0, 32'h3456, 32'h0);
      chk(res, 3'b010, "first");
      req(1'b0, 1'b0, 32'h0008, 32'h0);
      chk(res, 3'b010, "other");
      poll(32'h3456);
      chk(res, 3'b001, "ack");
      chk(pci_rdata, 32'h0c6e, "rd");
      $display("t_read done");
   endtask
   // 8-bit muxed read, then 16-bit muxed write with two waits
   task automatic t_mux();
      @(posedge mclk);
      bus_mux <= 1'b1;
      bus_wide <= 1'b0;
      cycle_wait_count <= 4'hd;
      poll(32'h7f31);
      chk(pci_rdata, 32'h25, "rd8");
      @(posedge mclk);
      bus_wide <= 1'b1;
      req(1'b1, 1'b0, 32'h0abc, 32'h1357);
      idle();
      chk({wr_a, wr_d}, 32'h0abc_1357, "mux16");
      @(posedge mclk);
      bus_mux <= 1'b0;
      cycle_wait_count <= 4'hf;
      $display("t_mux done");
   endtask
   // Arbitration slave held off, then ready-terminated write
   task automatic t_ready();
      @(posedge mclk);
      arb_master <= 1'b0;
      bus_granted <= 1'b0;
      ready_wait_enable <= 1'b1;
      cycle_wait_count <= 4'h2;
      rdy_dly <= 5'd12;
      req(1'b1, 1'b0, 32'h0100, 32'h77);
      count_low(20);
      chk(lows, 0, "nogrant");
      @(posedge mclk);
      bus_granted <= 1'b1;
      count_low(40);
      chk(lows > 12 && lows < 20, 1, "ready");
      idle();
      @(posedge mclk);
      arb_master <= 1'b1;
      ready_wait_enable <= 1'b0;
      cycle_wait_count <= 4'hf;
      $display("t_ready done");
   endtask
   task automatic t_pins();
      for (int c = 0; c < 8; c++) begin
         @(posedge mclk);
         peripheral_pin_config <= c[2:0];
         repeat (2) @(posedge mclk);
         #1;
         if (c inside {1, 5, 6, 7}) begin
            req(1'b0, 1'b0, 32'h10, 32'h0);
            chk(res, 3'b010, "rsv");
         end else begin
            chk({general_purpose_pins_en, local_mux_addr_data_en,
               sync_serial_block_en}, {((c >= 2) ? 8'hff : 8'h00),
               c == 3 || c == 4, c == 3}, "cfg");
         end
      end
      @(posedge mclk);
      peripheral_pin_config <= 3'h0;
      host_mode_a <= 1'b1;
      host_addr_in <= 32'h1234_9abc;
      req(1'b1, 1'b0, 32'h10, 32'h1);
      chk(res, 3'b010, "host");
      #1;
      chk({pins_host_addr, shared_addr_out}, 17'h1_9abc, "hpins");
      @(posedge mclk);
      host_mode_a <= 1'b0;
      $display("t_pins done");
   endtask
   initial begin
      repeat (4) @(posedge mclk);
      rst_b <= 1'b1;
      #1;
      chk({local_read_strobe, local_write_strobe, local_addr_latch_strobe},
         3'b110, "rst");
      t_write();
      t_read();
      t_mux();
      t_ready();
      t_pins();
      wrap_up();
   end
endmodule
